// ### hw/mar_params.svh
/*
 * offsets, field positions, reset values and timing counts of the monitor
 * result registers; assumes byte addressing within serial address A2h
 */
`ifndef MAR_PARAMS_SVH
`define MAR_PARAMS_SVH

`define MAR_OFS_TEMP_HIGH 8'h60
`define MAR_OFS_TEMP_LOW 8'h61
`define MAR_OFS_VOLT_HIGH 8'h62
`define MAR_OFS_VOLT_LOW 8'h63
`define MAR_OFS_BIAS_HIGH 8'h64
`define MAR_OFS_BIAS_LOW 8'h65
`define MAR_OFS_TXPWR_HIGH 8'h66
`define MAR_OFS_TXPWR_LOW 8'h67

`define MAR_CFG6_TEMP_HALF_BIT 1
`define MAR_TEMP_HALF_POS 7
`define MAR_RESULT_RESET 16'h0000
`define MAR_TEMP_RESET 9'h000
`define MAR_SLOPE_FRAC 8
`define MAR_RD_LATENCY 1

`endif

// ### hw/mar_pkg.sv
/*
 * types shared by the monitor result register block;
 * assumes nothing of its surroundings
 */
package mar_pkg;

    // scan order of the converter
    typedef enum logic [1:0] {
        MAR_CH_TEMP,
        MAR_CH_VOLT,
        MAR_CH_BIAS,
        MAR_CH_TXPWR
    } mar_chan_t;

    typedef logic [15:0] mar_pair_t;

endpackage

// ### hw/mar_cal_alu.sv
/*
 * slope and offset correction of one raw conversion;
 * assumes the raw byte is msb aligned and the coefficients are static
 */
`timescale 1ns/1ns
`include "mar_params.svh"

module mar_cal_alu (
    // raw conversion
    input wire logic [7:0] raw_byte,
    // coefficients: slope unsigned 8.8, offset signed
    input wire logic [15:0] slope,
    input wire logic [15:0] offset,
    // corrected result
    output mar_pkg::mar_pair_t corrected
);
    import mar_pkg::*;

    logic [31:0] prod;
    logic [23:0] scaled;
    logic signed [25:0] sum;

    assign prod = {16'h0000, raw_byte, 8'h00} * {16'h0000, slope};
    assign scaled = prod[23 + `MAR_SLOPE_FRAC:`MAR_SLOPE_FRAC];
    assign sum = $signed({2'b00, scaled}) + $signed({{10{offset[15]}}, offset});

    // clamp, since a negative offset or a steep slope can leave the range
    always_comb begin
        if (sum < 0) begin
            corrected = 16'h0000;
        end else if (sum > 26'sh000FFFF) begin
            corrected = 16'hFFFF;
        end else begin
            corrected = sum[15:0];
        end
    end

endmodule

// ### hw/mar_temp_fmt.sv
/*
 * formats the stored nine-bit temperature into its register byte pair;
 * assumes the input counts half degrees in two's complement
 */
`timescale 1ns/1ns
`include "mar_params.svh"

module mar_temp_fmt (
    // stored result and resolution option
    input wire logic [8:0] temp_half,
    input wire logic half_res_en,
    // register bytes
    output logic [7:0] high,
    output logic [7:0] low
);
    import mar_pkg::*;

    // high byte is whole degrees, sign kept
    assign high = temp_half[8:1]; // RL1

    always_comb begin
        low = 8'h00; // RL2
        if (half_res_en) begin
            low[`MAR_TEMP_HALF_POS] = temp_half[0]; // RL3
        end
    end

endmodule

// ### hw/mar_result_regs.sv
/*
 * monitor converter result registers, bytes 60h to 67h of serial address
 * A2h, with read port, optional internal calibration and first-cycle gating;
 * assumes a serial port engine that presents byte reads and writes
 * synchronous to clk_sys and a converter that scans all four channels
 */
`timescale 1ns/1ns
`include "mar_params.svh"

// Operation
// RL1: temperature is signed two's complement, one degree per high byte step.
// RL2: with config six bit 1 low, whole degrees only, low byte zero.
// RL3: with config six bit 1 high, half degree in low byte msb.
// RL4: temperature high byte shows a measurement only after first conversion.
// RL5: voltage is unsigned 16 bits, 25.6 mV high step, 0.1 mV low.
// RL6: external mode: raw voltage byte in high byte, low byte zero.
// RL7: internal mode: slope and offset correct voltage, bias and power.
// RL8: external mode: host applies the coefficients itself.
// RL9: bias is unsigned 16 bits, 512 uA high step, 2 uA low.
// RL10: external mode: raw bias byte in high byte, low byte zero.
// RL11: power is unsigned 16 bits, 25.6 uW high step, 0.1 uW low.
// RL12: external mode: raw power byte in high byte, low byte zero.
// RL13: voltage, bias, power read zero until one full scan completes.
// RL14: pairs high byte first: temp 96, voltage, bias, power to 103.
// RL15: writes to result registers are ignored, results unchanged.
module mar_result_regs #(
    parameter int ADC_W = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,

    // converter results
    input wire logic conv_valid,
    input wire mar_pkg::mar_chan_t conv_chan,
    input wire logic [ADC_W-1:0] conv_raw,
    input wire logic [8:0] conv_temp,

    // calibration setup
    input wire logic internal_cal_mode,
    input wire logic [7:0] factory_config_reg_six,
    input wire logic [15:0] voltage_slope_coeff,
    input wire logic [15:0] voltage_offset_coeff,
    input wire logic [15:0] bias_slope_coeff,
    input wire logic [15:0] bias_offset_coeff,
    input wire logic [15:0] tx_power_slope_coeff,
    input wire logic [15:0] tx_power_offset_coeff,

    // byte register port
    input wire logic reg_rd_en,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    output logic [7:0] reg_rd_data,
    output logic reg_rd_hit,
    output logic reg_wr_ignored,

    // status
    output logic first_cycle_busy
);
    import mar_pkg::*;

    localparam int NCH = 3;

    if (ADC_W < 1 || ADC_W > 8) begin : g_bad_width
        $error("ADC_W must lie between 1 and 8");
    end

    logic [7:0] raw_byte;
    logic [15:0] slope_sel [NCH];
    logic [15:0] offset_sel [NCH];
    mar_pair_t pair_q [NCH];
    logic [8:0] temp_q;
    logic [3:0] seen;
    logic cycle_done;
    logic temp_seen;
    logic [7:0] temp_high;
    logic [7:0] temp_low;
    logic [7:0] next_rd_data;
    logic next_rd_hit;
    logic in_range;

    // narrow converters are msb aligned so full scale stays full scale
    assign raw_byte = 8'(conv_raw) << (8 - ADC_W);

    assign slope_sel[0] = voltage_slope_coeff;
    assign slope_sel[1] = bias_slope_coeff;
    assign slope_sel[2] = tx_power_slope_coeff;
    assign offset_sel[0] = voltage_offset_coeff;
    assign offset_sel[1] = bias_offset_coeff;
    assign offset_sel[2] = tx_power_offset_coeff;

    // voltage, bias and power share one structure
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        mar_pair_t corrected;

        mar_cal_alu u_alu (
            .raw_byte(raw_byte),
            .slope(slope_sel[i]),
            .offset(offset_sel[i]),
            .corrected(corrected)
        );

        always_ff @(posedge clk_sys) begin
            if (rst) begin
                pair_q[i] <= `MAR_RESULT_RESET; // RL13
            end else if (conv_valid && conv_chan == mar_chan_t'(i + 1)) begin
                if (internal_cal_mode) begin
                    pair_q[i] <= corrected; // RL7
                end else begin
                    // raw byte only: correction is left to the host
                    pair_q[i] <= {raw_byte, 8'h00}; // RL6 RL10 RL12
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            temp_q <= `MAR_TEMP_RESET;
        end else if (conv_valid && conv_chan == MAR_CH_TEMP) begin
            temp_q <= conv_temp; // RL1
        end
    end

    // one bit per channel; a full scan is every channel seen once
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            seen <= 4'h0;
        end else if (conv_valid) begin
            seen[conv_chan] <= 1'b1;
        end
    end

    assign cycle_done = &seen;
    assign temp_seen = seen[MAR_CH_TEMP];
    assign first_cycle_busy = ~cycle_done;

    // format at read time so a resolution change applies at once
    mar_temp_fmt u_temp (
        .temp_half(temp_q),
        .half_res_en(factory_config_reg_six[`MAR_CFG6_TEMP_HALF_BIT]),
        .high(temp_high),
        .low(temp_low)
    );

    always_comb begin
        next_rd_data = 8'h00;
        next_rd_hit = 1'b1;
        case (reg_addr) // RL14
            `MAR_OFS_TEMP_HIGH: begin
                next_rd_data = temp_seen ? temp_high : 8'h00; // RL4
            end
            `MAR_OFS_TEMP_LOW: begin
                next_rd_data = temp_seen ? temp_low : 8'h00; // RL2 RL3
            end
            `MAR_OFS_VOLT_HIGH: begin
                next_rd_data = cycle_done ? pair_q[0][15:8] : 8'h00; // RL5 RL13
            end
            `MAR_OFS_VOLT_LOW: begin
                next_rd_data = cycle_done ? pair_q[0][7:0] : 8'h00; // RL5 RL13
            end
            `MAR_OFS_BIAS_HIGH: begin
                next_rd_data = cycle_done ? pair_q[1][15:8] : 8'h00; // RL9 RL13
            end
            `MAR_OFS_BIAS_LOW: begin
                next_rd_data = cycle_done ? pair_q[1][7:0] : 8'h00; // RL9 RL13
            end
            `MAR_OFS_TXPWR_HIGH: begin
                next_rd_data = cycle_done ? pair_q[2][15:8] : 8'h00; // RL11 RL13
            end
            `MAR_OFS_TXPWR_LOW: begin
                next_rd_data = cycle_done ? pair_q[2][7:0] : 8'h00; // RL11 RL13
            end
            default: begin
                next_rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rd_data <= 8'h00;
            reg_rd_hit <= 1'b0;
        end else if (reg_rd_en) begin
            reg_rd_data <= next_rd_data;
            reg_rd_hit <= next_rd_hit;
        end else begin
            reg_rd_hit <= 1'b0;
        end
    end

    assign in_range = reg_addr >= `MAR_OFS_TEMP_HIGH && reg_addr <= `MAR_OFS_TXPWR_LOW;

    // no path from reg_wr_data to any result; only a flag is raised
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_wr_ignored <= 1'b0;
        end else begin
            reg_wr_ignored <= reg_wr_en && in_range; // RL15
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking

    default disable iff (rst);

    chk_ext_volt_raw: assert property ( // RL6
        conv_valid && conv_chan == MAR_CH_VOLT && !internal_cal_mode
        |=> pair_q[0] == {$past(raw_byte), 8'h00})
        else $error("voltage raw result not placed in high byte");

    chk_ext_bias_raw: assert property ( // RL10
        conv_valid && conv_chan == MAR_CH_BIAS && !internal_cal_mode
        |=> pair_q[1][15:8] == $past(raw_byte) && pair_q[1][7:0] == 8'h00)
        else $error("bias raw result wrong");

    chk_ext_txpwr_raw: assert property ( // RL12
        conv_valid && conv_chan == MAR_CH_TXPWR && !internal_cal_mode
        |=> pair_q[2][15:8] == $past(raw_byte) && pair_q[2][7:0] == 8'h00)
        else $error("power raw result wrong");

    chk_int_unity_cal: assert property ( // RL7
        conv_valid && conv_chan == MAR_CH_VOLT && internal_cal_mode
        && voltage_slope_coeff == 16'h0100 && voltage_offset_coeff == 16'h0000
        |=> pair_q[0] == {$past(raw_byte), 8'h00})
        else $error("unity calibration changed the voltage result");

    chk_int_offset_cal: assert property ( // RL7
        conv_valid && conv_chan == MAR_CH_BIAS && internal_cal_mode
        && bias_slope_coeff == 16'h0000 && bias_offset_coeff[15] == 1'b0
        |=> pair_q[1] == $past(bias_offset_coeff))
        else $error("bias offset not applied");

    chk_temp_whole_low: assert property ( // RL2
        reg_rd_en && reg_addr == `MAR_OFS_TEMP_LOW
        && !factory_config_reg_six[`MAR_CFG6_TEMP_HALF_BIT]
        |=> reg_rd_data == 8'h00)
        else $error("low temperature byte not zero in whole degree mode");

    chk_temp_half_low: assert property ( // RL3
        reg_rd_en && reg_addr == `MAR_OFS_TEMP_LOW && temp_seen
        && factory_config_reg_six[`MAR_CFG6_TEMP_HALF_BIT]
        |=> reg_rd_data == {$past(temp_q[0]), 7'h00})
        else $error("half degree bit misplaced");

    chk_temp_high_read: assert property ( // RL1
        reg_rd_en && reg_addr == `MAR_OFS_TEMP_HIGH && temp_seen
        |=> reg_rd_data == $past(temp_q[8:1]) && reg_rd_hit)
        else $error("temperature high byte wrong");

    chk_temp_before_conv: assert property ( // RL4
        reg_rd_en && reg_addr == `MAR_OFS_TEMP_HIGH && !temp_seen
        |=> reg_rd_data == 8'h00)
        else $error("temperature shown before first conversion");

    chk_pair_hidden: assert property ( // RL13
        reg_rd_en && reg_addr >= `MAR_OFS_VOLT_HIGH
        && reg_addr <= `MAR_OFS_TXPWR_LOW && !cycle_done
        |=> reg_rd_data == 8'h00 && reg_rd_hit)
        else $error("result visible before a full scan");

    chk_map_order: assert property ( // RL14
        reg_rd_en && reg_addr == `MAR_OFS_BIAS_LOW && cycle_done
        |=> reg_rd_data == $past(pair_q[1][7:0]))
        else $error("bias low byte read from wrong place");

    chk_write_ignored: assert property ( // RL15
        reg_wr_en && in_range && !conv_valid
        |=> $stable(pair_q[0]) && $stable(temp_q) && reg_wr_ignored)
        else $error("write disturbed a result register");

    chk_busy_status: assert property ( // RL13
        conv_valid && seen == 4'h7 && conv_chan == MAR_CH_TXPWR
        |=> !first_cycle_busy ##1 !first_cycle_busy)
        else $error("busy did not clear after the full scan");

    chk_rd_hit_range: assert property ( // RL14
        reg_rd_en && in_range
        |=> reg_rd_hit)
        else $error("read inside the result window not flagged");

    chk_rd_miss: assert property ( // RL14
        reg_rd_en && !in_range
        |=> !reg_rd_hit && reg_rd_data == 8'h00)
        else $error("read outside the result window returned data");

    chk_hit_pulse: assert property ( // RL14
        !reg_rd_en
        |=> !reg_rd_hit)
        else $error("read flag stayed high without a read");

    // rst in the antecedent: a reset edge clears the byte without a read
    chk_rd_data_holds: assert property ( // RL14
        !reg_rd_en && !rst
        |=> $stable(reg_rd_data))
        else $error("read data changed without a read");

    chk_volt_high_read: assert property ( // RL5
        reg_rd_en && reg_addr == `MAR_OFS_VOLT_HIGH && cycle_done
        |=> reg_rd_data == $past(pair_q[0][15:8]))
        else $error("voltage high byte wrong");

    chk_volt_low_read: assert property ( // RL5
        reg_rd_en && reg_addr == `MAR_OFS_VOLT_LOW && cycle_done
        |=> reg_rd_data == $past(pair_q[0][7:0]))
        else $error("voltage low byte wrong");

    chk_bias_high_read: assert property ( // RL9
        reg_rd_en && reg_addr == `MAR_OFS_BIAS_HIGH && cycle_done
        |=> reg_rd_data == $past(pair_q[1][15:8]))
        else $error("bias high byte wrong");

    chk_txpwr_high_read: assert property ( // RL11
        reg_rd_en && reg_addr == `MAR_OFS_TXPWR_HIGH && cycle_done
        |=> reg_rd_data == $past(pair_q[2][15:8]))
        else $error("power high byte wrong");

    chk_txpwr_low_read: assert property ( // RL11
        reg_rd_en && reg_addr == `MAR_OFS_TXPWR_LOW && cycle_done
        |=> reg_rd_data == $past(pair_q[2][7:0]))
        else $error("power low byte wrong");

    chk_temp_store: assert property ( // RL1
        conv_valid && conv_chan == MAR_CH_TEMP
        |=> temp_q == $past(conv_temp))
        else $error("temperature result not stored");

    chk_busy_stays: assert property ( // RL13
        !first_cycle_busy && !rst
        |=> !first_cycle_busy)
        else $error("busy rose again without a reset");

    chk_int_clamp_high: assert property ( // RL7
        conv_valid && conv_chan == MAR_CH_BIAS && internal_cal_mode
        && raw_byte >= 8'h80 && bias_slope_coeff >= 16'h0200 && !bias_offset_coeff[15]
        |=> pair_q[1] == 16'hFFFF)
        else $error("bias result did not saturate high");

    chk_int_clamp_low: assert property ( // RL7
        conv_valid && conv_chan == MAR_CH_TXPWR && internal_cal_mode
        && raw_byte == 8'h00 && tx_power_offset_coeff[15]
        |=> pair_q[2] == 16'h0000)
        else $error("power result did not saturate low");

    chk_wr_flag_range: assert property ( // RL15
        reg_wr_en && !in_range
        |=> !reg_wr_ignored)
        else $error("write outside the window flagged");

    chk_wr_flag_pulse: assert property ( // RL15
        !reg_wr_en
        |=> !reg_wr_ignored)
        else $error("write flag stayed high without a write");

endmodule

// ### dv/mar_conv_model.sv
/*
 * converter model feeding results into the monitor result registers;
 * assumes the bench calls convert from one process at a time
 */
`timescale 1ns/1ns

module mar_conv_model (
    // clock
    input wire logic clk_sys,
    // result strobe and data
    output logic conv_valid,
    output mar_pkg::mar_chan_t conv_chan,
    output logic [7:0] conv_raw,
    output logic [8:0] conv_temp
);
    import mar_pkg::*;

    initial begin
        conv_valid = 1'b0;
        conv_chan = MAR_CH_TEMP;
        conv_raw = 8'h00;
        conv_temp = 9'h000;
    end

    // data is inverted once the strobe drops so a stale value never reads as valid
    task automatic convert(input mar_chan_t ch, input logic [7:0] r, input logic [8:0] t);
        @(posedge clk_sys);
        conv_valid <= 1'b1;
        conv_chan <= ch;
        conv_raw <= r;
        conv_temp <= t;
        @(posedge clk_sys);
        conv_valid <= 1'b0;
        conv_raw <= ~r;
        conv_temp <= ~t;
    endtask
endmodule

// ### dv/monitor_adc_result_regs_tb.sv
/*
 * self-checking bench of the monitor result registers;
 * assumes the converter model and the design files are compiled first
 */
`timescale 1ns/1ns

module monitor_adc_result_regs_tb;
    import mar_pkg::*;

    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic cal_int = 1'b0;
    logic [7:0] cfg6 = 8'h00;
    logic [15:0] v_slp = 16'h0100;
    logic [15:0] v_off = 16'h0005;
    logic [15:0] b_slp = 16'h0200;
    logic [15:0] b_off = 16'h0000;
    logic [15:0] p_slp = 16'h0100;
    logic [15:0] p_off = 16'hFFF0;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic hit;
    logic wign;
    logic busy;
    logic conv_valid;
    mar_chan_t conv_chan;
    logic [7:0] conv_raw;
    logic [8:0] conv_temp;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;

    always #4 clk_sys = ~clk_sys;

    mar_conv_model model (.clk_sys(clk_sys), .conv_valid(conv_valid),
        .conv_chan(conv_chan), .conv_raw(conv_raw), .conv_temp(conv_temp));

    mar_result_regs #(.ADC_W(8)) dut (.clk_sys(clk_sys), .rst(rst),
        .conv_valid(conv_valid), .conv_chan(conv_chan), .conv_raw(conv_raw),
        .conv_temp(conv_temp), .internal_cal_mode(cal_int),
        .factory_config_reg_six(cfg6),
        .voltage_slope_coeff(v_slp), .voltage_offset_coeff(v_off),
        .bias_slope_coeff(b_slp), .bias_offset_coeff(b_off),
        .tx_power_slope_coeff(p_slp), .tx_power_offset_coeff(p_off),
        .reg_rd_en(rd_en), .reg_wr_en(wr_en), .reg_addr(addr),
        .reg_wr_data(wdata), .reg_rd_data(rdata), .reg_rd_hit(hit),
        .reg_wr_ignored(wign), .first_cycle_busy(busy));

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        chk8($sformatf("byte %h", a), exp, rdata);
        chk1("read hit", a[7:3] == 5'h0C, hit);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr_en <= 1'b0;
        #1;
        chk1("write ignored flag", a[7:3] == 5'h0C, wign);
    endtask

    task automatic give_verdict();
        if (fails == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // the whole run needs well under 400 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            give_verdict();
        end
    end

    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk1("busy after reset", 1'b1, busy);
        for (int a = 8'h60; a <= 8'h68; a++) begin
            rd(a[7:0], 8'h00);
        end
        model.convert(MAR_CH_TEMP, 8'h00, 9'h0A3);
        rd(8'h60, 8'h51);
        rd(8'h61, 8'h00);
        @(posedge clk_sys);
        cfg6 <= 8'h02;
        rd(8'h61, 8'h80);
        model.convert(MAR_CH_VOLT, 8'hAB, 9'h000);
        rd(8'h62, 8'h00);
        model.convert(MAR_CH_BIAS, 8'h3C, 9'h000);
        model.convert(MAR_CH_TXPWR, 8'hC5, 9'h000);
        // raw codes below; the host scales them itself
        rd(8'h62, 8'hAB);
        rd(8'h63, 8'h00);
        rd(8'h64, 8'h3C);
        rd(8'h65, 8'h00);
        rd(8'h66, 8'hC5);
        rd(8'h67, 8'h00);
        chk1("busy after full scan", 1'b0, busy);
        model.convert(MAR_CH_TEMP, 8'h00, 9'h1FF);
        rd(8'h60, 8'hFF);
        rd(8'h61, 8'h80);
        wr(8'h62, 8'h55);
        wr(8'h60, 8'h00);
        rd(8'h62, 8'hAB);
        rd(8'h60, 8'hFF);
        @(posedge clk_sys);
        cal_int <= 1'b1;
        model.convert(MAR_CH_VOLT, 8'h12, 9'h000);
        model.convert(MAR_CH_BIAS, 8'h90, 9'h000);
        model.convert(MAR_CH_TXPWR, 8'h00, 9'h000);
        rd(8'h62, 8'h12);
        rd(8'h63, 8'h05);
        rd(8'h64, 8'hFF);
        rd(8'h65, 8'hFF);
        rd(8'h66, 8'h00);
        rd(8'h67, 8'h00);
        // unity voltage slope and a pure bias offset
        @(posedge clk_sys);
        v_off <= 16'h0000;
        b_slp <= 16'h0000;
        b_off <= 16'h1234;
        model.convert(MAR_CH_VOLT, 8'h34, 9'h000);
        model.convert(MAR_CH_BIAS, 8'h77, 9'h000);
        rd(8'h62, 8'h34);
        rd(8'h63, 8'h00);
        rd(8'h64, 8'h12);
        rd(8'h65, 8'h34);
        wr(8'h68, 8'hAA);
        // a second reset must hide every result again
        @(posedge clk_sys);
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk1("busy after second reset", 1'b1, busy);
        rd(8'h60, 8'h00);
        rd(8'h62, 8'h00);
        rd(8'h65, 8'h00);
        give_verdict();
    end
endmodule
